// file: src/uncore_event_counter_unit.sv
`timescale 1ns/100ps
// Functional notes
// RULE_01: event code bits 7:0 and qualifier bits 15:8 pick the counted condition.
// RULE_02: edge bit 18 counts rising edges of the filtered event.
// RULE_03: bit 20 forwards the counter overflow to global control.
// RULE_04: local enable bit 22 must be set, otherwise the counter holds.
// RULE_05: negate bit 23 inverts the filter result.
// RULE_06: 5-bit threshold in bits 28:24 filters the raw event count.
// RULE_07: overflow raises perf_interrupt to each core with route bit 3:0 set.
// RULE_08: wake bit 30 sends a wake request before the interrupt.
// RULE_09: global enable bit 29 gates fixed, grant and slice counters.
// RULE_10: with stop bit 31, any overflow clears the global enable.
// RULE_11: a halted core without a wake request misses the interrupt.
// RULE_12: software also sets bit 13 of the core debug control register.
// RULE_13: one fixed 48-bit counter counts every clock under global enable.
// RULE_14: each of up to four slices has two 44-bit counters with selects.
// RULE_15: grant unit has two 44-bit counters with selects under global enable.
// RULE_16: occupancy events count only on slice counter 0.
// RULE_17: other slice events may use either counter.
// RULE_18: counters count with both enables, wrap to zero and flag overflow.
// RULE_19: undefined bits read zero; global control resets to zero.
module uncore_event_counter_unit #(
  parameter int NUM_SLICES = 4,
  parameter int N_EV       = 16
) (
  // clock and reset
  input  wire logic                                  core_clk,
  input  wire logic                                  rst_n,
  // register access
  input  wire uncore_evc_pkg::msr_req_t              msr_req,
  output logic      [63:0]                           msr_rdata,
  output logic                                       msr_ack,
  // grant unit event sources
  input  wire logic [uncore_evc_pkg::COND_W-1:0]     grant_cond [N_EV],
  // slice event sources
  input  wire logic [uncore_evc_pkg::COND_W-1:0]     slice_cond [NUM_SLICES][N_EV],
  input  wire logic [uncore_evc_pkg::RAW_W-1:0]      slice_occupancy [NUM_SLICES],
  // toward the cores
  output logic      [uncore_evc_pkg::NUM_CORES-1:0]  wake_req,
  output logic      [uncore_evc_pkg::NUM_CORES-1:0]  perf_interrupt
);
  import uncore_evc_pkg::*;

  localparam int NGP = 2 + 2 * NUM_SLICES;

  // reset release through two flops
  logic rst_s1_q, rst_s2_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire logic rst_i_n = rst_s2_q;

  // index of event select i; grant first, then slices
  function automatic logic [7:0] sel_index(input int i);
    return (i < 2) ? IDX_GRANT_SEL + 8'(i) : IDX_SLICE_SEL + 8'(i - 2);
  endfunction : sel_index

  function automatic logic [7:0] ctr_index(input int i);
    return (i < 2) ? IDX_GRANT_CTR + 8'(i) : IDX_SLICE_CTR + 8'(i - 2);
  endfunction : ctr_index

  logic                wr;
  logic                rd;
  gctrl_t              gctrl_q, gctrl_d;
  evsel_t              sel_q [NGP];
  evsel_t              sel_d [NGP];
  logic [NGP-1:0]      ld;
  logic [GP_WIDTH-1:0] gp_count [NGP];
  logic [NGP-1:0]      gp_ovf;
  logic [NGP-1:0]      fwd_ovf;
  logic [FIX_WIDTH-1:0] fix_q, fix_d;
  logic                fix_ovf_q, fix_ovf_d;
  logic                any_ovf, route_ovf;
  logic [63:0]         rdata_q, rdata_d;
  logic                ack_q, ack_d;

  assign wr = msr_req.req & msr_req.we;
  assign rd = msr_req.req & ~msr_req.we;

  // event select registers; reserved bits never stored
  always_comb begin
    for (int i = 0; i < NGP; i++) begin
      sel_d[i] = sel_q[i];
      ld[i]    = wr && (msr_req.addr == ctr_index(i));
      if (wr && msr_req.addr == sel_index(i)) begin
        // RULE_19: reserved bits zero
        sel_d[i] = evsel_t'(msr_req.wdata & EVSEL_RW_MASK);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      for (int i = 0; i < NGP; i++) begin
        sel_q[i] <= evsel_t'(EVSEL_RESET);
      end
    end else begin
      for (int i = 0; i < NGP; i++) begin
        sel_q[i] <= sel_d[i];
      end
    end
  end

  // grant unit counters, no occupancy events there
  // RULE_15: grant counters
  for (genvar g = 0; g < 2; g++) begin : g_grant
    evt_counter #(
      .WIDTH  (GP_WIDTH),
      .N_EV   (N_EV),
      .OCC_OK (1'b0)
    ) u_ctr (
      .clk       (core_clk),
      .rst_n     (rst_i_n),
      .sel       (sel_q[g]),
      .glob_en   (gctrl_q.enable),
      .cond      (grant_cond),
      .occupancy ('0),
      .ld        (ld[g]),
      .ld_val    (msr_req.wdata[GP_WIDTH-1:0]),
      .count     (gp_count[g]),
      .ovf       (gp_ovf[g])
    );
  end

  // slice counters; both get the occupancy value, only counter 0 counts it
  // RULE_14: two per slice
  for (genvar s = 0; s < NUM_SLICES; s++) begin : g_slice
    for (genvar c = 0; c < 2; c++) begin : g_ctr
      evt_counter #(
        .WIDTH  (GP_WIDTH),
        .N_EV   (N_EV),
        .OCC_OK (c == 0)
      ) u_ctr (
        .clk       (core_clk),
        .rst_n     (rst_i_n),
        .sel       (sel_q[2 + 2 * s + c]),
        .glob_en   (gctrl_q.enable),
        .cond      (slice_cond[s]),
        .occupancy (slice_occupancy[s]),
        .ld        (ld[2 + 2 * s + c]),
        .ld_val    (msr_req.wdata[GP_WIDTH-1:0]),
        .count     (gp_count[2 + 2 * s + c]),
        .ovf       (gp_ovf[2 + 2 * s + c])
      );
    end
  end

  // fixed clocktick counter, always counts while globally enabled
  always_comb begin
    fix_d     = fix_q;
    fix_ovf_d = 1'b0;
    if (wr && msr_req.addr == IDX_FIXED_CTR) begin
      fix_d = msr_req.wdata[FIX_WIDTH-1:0];
    // RULE_13: fixed clocktick
    // RULE_09: global gate
    end else if (gctrl_q.enable) begin
      fix_d     = fix_q + FIX_WIDTH'(1);
      fix_ovf_d = &fix_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      fix_q     <= '0;
      fix_ovf_q <= 1'b0;
    end else begin
      fix_q     <= fix_d;
      fix_ovf_q <= fix_ovf_d;
    end
  end

  // overflow collection; forwarded and fixed counter overflows reach the cores
  always_comb begin
    for (int i = 0; i < NGP; i++) begin
      // RULE_03: forward when enabled
      fwd_ovf[i] = gp_ovf[i] & sel_q[i].overflow_forward_enable;
    end
    route_ovf = (|fwd_ovf) | fix_ovf_q;
    any_ovf   = (|gp_ovf) | fix_ovf_q;
  end

  // global control; a freeze in the same cycle as a write wins
  always_comb begin
    gctrl_d = gctrl_q;
    if (wr && msr_req.addr == IDX_GLOBAL_CTRL) begin
      gctrl_d = gctrl_t'(msr_req.wdata & GCTRL_RW_MASK);
    end
    // RULE_10: freeze on overflow
    if (gctrl_q.stop_all_on_overflow && any_ovf) begin
      gctrl_d.enable = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      // RULE_19: reset to zero
      gctrl_q <= gctrl_t'(GCTRL_RESET);
    end else begin
      gctrl_q <= gctrl_d;
    end
  end

  // interrupt and wake delivery
  irq_route #(
    .NCORE (NUM_CORES)
  ) u_route (
    .clk            (core_clk),
    .rst_n          (rst_i_n),
    .ovf_evt        (route_ovf),
    .route          (gctrl_q.core_interrupt_route),
    .wake_en        (gctrl_q.wake_before_interrupt),
    .wake_req       (wake_req),
    .perf_interrupt (perf_interrupt)
  );

  // read path, answered one cycle after the request; unmapped reads zero
  always_comb begin
    rdata_d = rdata_q;
    ack_d   = msr_req.req;
    if (rd) begin
      rdata_d = '0;
      if (msr_req.addr == IDX_GLOBAL_CTRL) begin
        rdata_d = 64'(gctrl_q);
      end
      if (msr_req.addr == IDX_FIXED_CTR) begin
        rdata_d = 64'(fix_q);
      end
      for (int i = 0; i < NGP; i++) begin
        if (msr_req.addr == sel_index(i)) begin
          rdata_d = 64'(sel_q[i]);
        end
        if (msr_req.addr == ctr_index(i)) begin
          rdata_d = 64'(gp_count[i]);
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      rdata_q <= '0;
      ack_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ack_q   <= ack_d;
    end
  end

  assign msr_rdata = rdata_q;
  assign msr_ack   = ack_q;

endmodule : uncore_event_counter_unit

// file: src/uncore_evc_pkg.sv
package uncore_evc_pkg;

  // geometry
  localparam int NUM_CORES   = 4;
  localparam int GP_WIDTH    = 44;
  localparam int FIX_WIDTH   = 48;
  localparam int RAW_W       = 5;
  localparam int COND_W      = 8;
  localparam int MSR_AW      = 8;

  // register indices on the msr port
  localparam logic [7:0] IDX_GLOBAL_CTRL  = 8'h00;
  localparam logic [7:0] IDX_FIXED_CTR    = 8'h01;
  localparam logic [7:0] IDX_GRANT_SEL    = 8'h10;
  localparam logic [7:0] IDX_GRANT_CTR    = 8'h12;
  localparam logic [7:0] IDX_SLICE_SEL    = 8'h20;
  localparam logic [7:0] IDX_SLICE_CTR    = 8'h30;

  // event codes at or above this value are occupancy events
  localparam logic [7:0] OCC_EVENT_BASE   = 8'h80;

  // writable bits; everything else is reserved and reads as zero
  localparam logic [63:0] EVSEL_RW_MASK   = 64'h0000_0000_1fd4_ffff;
  localparam logic [63:0] GCTRL_RW_MASK   = 64'h0000_0000_e000_000f;
  localparam logic [63:0] EVSEL_RESET     = 64'h0000_0000_0000_0000;
  localparam logic [63:0] GCTRL_RESET     = 64'h0000_0000_0000_0000;

  // event select layout
  typedef struct packed {
    logic [34:0] rsvd_hi;
    logic [4:0]  threshold_value;
    logic        negate_count;
    logic        enable;
    logic        rsvd_21;
    logic        overflow_forward_enable;
    logic        rsvd_19;
    logic        edge_detect;
    logic [1:0]  rsvd_17_16;
    logic [7:0]  condition_qualifier;
    logic [7:0]  event_code;
  } evsel_t;

  // global control layout
  typedef struct packed {
    logic [31:0] rsvd_hi;
    logic        stop_all_on_overflow;
    logic        wake_before_interrupt;
    logic        enable;
    logic [24:0] rsvd_mid;
    logic [3:0]  core_interrupt_route;
  } gctrl_t;

  // register access request on the msr port
  typedef struct packed {
    logic        req;
    logic        we;
    logic [7:0]  addr;
    logic [63:0] wdata;
  } msr_req_t;

endpackage : uncore_evc_pkg

// file: src/evt_counter.sv
`timescale 1ns/100ps
module evt_counter #(
  parameter int WIDTH  = 44,
  parameter int N_EV   = 16,
  parameter bit OCC_OK = 1'b0
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // control
  input  wire uncore_evc_pkg::evsel_t        sel,
  input  wire logic                          glob_en,
  // event sources
  input  wire logic [uncore_evc_pkg::COND_W-1:0] cond [N_EV],
  input  wire logic [uncore_evc_pkg::RAW_W-1:0]  occupancy,
  // software load
  input  wire logic                          ld,
  input  wire logic [WIDTH-1:0]              ld_val,
  // state
  output logic      [WIDTH-1:0]              count,
  output logic                               ovf
);
  import uncore_evc_pkg::*;

  logic [WIDTH-1:0] cnt_q, cnt_d;
  logic             prev_q, prev_d;
  logic             ovf_q, ovf_d;
  logic [RAW_W-1:0] raw, thr;
  logic             cmp, inc_bit;
  logic [WIDTH:0]   sum;

  function automatic logic [RAW_W-1:0] popcount(input logic [COND_W-1:0] v);
    logic [RAW_W-1:0] n;
    n = '0;
    for (int b = 0; b < COND_W; b++) begin
      n = n + RAW_W'(v[b]);
    end
    return n;
  endfunction : popcount

  // event selection, threshold, negation and edge filtering
  always_comb begin
    raw = '0;
    // RULE_01: code and qualifier
    if (sel.event_code >= OCC_EVENT_BASE) begin
      // RULE_16: occupancy only on counter 0
      raw = OCC_OK ? occupancy : '0;
    end else begin
      // RULE_17: other events on either
      for (int e = 0; e < N_EV; e++) begin
        if (sel.event_code == 8'(e)) begin
          raw = popcount(cond[e] & sel.condition_qualifier);
        end
      end
    end
    // RULE_06: threshold filter, zero means one
    thr = (sel.threshold_value == '0) ? RAW_W'(1) : sel.threshold_value;
    // RULE_05: negate the compare result
    cmp = (raw >= thr) ^ sel.negate_count;
    // RULE_02: edge detection
    inc_bit = sel.edge_detect ? (cmp & ~prev_q) : cmp;
    prev_d  = cmp;
  end

  // counting; plain raw sum only when no filter is asked for
  always_comb begin
    if (sel.threshold_value == '0 && !sel.negate_count && !sel.edge_detect) begin
      sum = {1'b0, cnt_q} + (WIDTH+1)'(raw);
    end else begin
      sum = {1'b0, cnt_q} + (WIDTH+1)'(inc_bit);
    end
    cnt_d = cnt_q;
    ovf_d = 1'b0;
    if (ld) begin
      cnt_d = ld_val;
    // RULE_04: local enable
    // RULE_18: both enables, wrap and flag
    end else if (sel.enable && glob_en) begin
      cnt_d = sum[WIDTH-1:0];
      ovf_d = sum[WIDTH];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      prev_q <= 1'b0;
      ovf_q  <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      prev_q <= prev_d;
      ovf_q  <= ovf_d;
    end
  end

  assign count = cnt_q;
  assign ovf   = ovf_q;

endmodule : evt_counter

// file: src/irq_route.sv
`timescale 1ns/100ps
module irq_route #(
  parameter int NCORE = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // overflow event and routing
  input  wire logic             ovf_evt,
  input  wire logic [NCORE-1:0] route,
  input  wire logic             wake_en,
  // toward the cores
  output logic      [NCORE-1:0] wake_req,
  output logic      [NCORE-1:0] perf_interrupt
);
  logic [NCORE-1:0] wake_q, wake_d, int_q, int_d, pend_q, pend_d;

  // wake goes one cycle ahead of the interrupt it belongs to
  always_comb begin
    wake_d = '0;
    int_d  = pend_q;
    pend_d = '0;
    if (ovf_evt) begin
      if (wake_en) begin
        // RULE_08: wake first
        wake_d = route;
        pend_d = route;
      end else begin
        // RULE_07: route per core
        // RULE_11: a halted core misses this one
        int_d = pend_q | route;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_q <= '0;
      int_q  <= '0;
      pend_q <= '0;
    end else begin
      wake_q <= wake_d;
      int_q  <= int_d;
      pend_q <= pend_d;
    end
  end

  assign wake_req       = wake_q;
  assign perf_interrupt = int_q;

endmodule : irq_route

// file: bench/uncore_event_counter_unit_checker.sv
`timescale 1ns/100ps
module uncore_event_counter_unit_checker (
  // clock and reset
  input wire logic                     core_clk,
  input wire logic                     rst_n,
  // register port
  input wire uncore_evc_pkg::msr_req_t msr_req,
  input wire logic [63:0]              msr_rdata,
  input wire logic                     msr_ack,
  // toward the cores
  input wire logic [3:0]               wake_req,
  input wire logic [3:0]               perf_interrupt
);
  import uncore_evc_pkg::*;
  logic [3:0] route_q;
  logic       wake_q;
  logic       rd_gc_q;
  logic       rd_es_q;
  logic       rd_un_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // routing fields mirrored from writes; freeze never touches them
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      route_q <= 4'h0;
      wake_q  <= 1'b0;
    end else if (msr_req.req && msr_req.we && msr_req.addr == IDX_GLOBAL_CTRL) begin
      route_q <= msr_req.wdata[3:0];
      wake_q  <= msr_req.wdata[30];
    end
  end
  // kind of the last read request, so that each ack can be matched to what was asked
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_gc_q <= 1'b0;
      rd_es_q <= 1'b0;
      rd_un_q <= 1'b0;
    end else begin
      rd_gc_q <= msr_req.req && !msr_req.we && msr_req.addr == IDX_GLOBAL_CTRL;
      rd_es_q <= msr_req.req && !msr_req.we &&
                 msr_req.addr inside {[8'h10:8'h11], [8'h20:8'h27]};
      rd_un_q <= msr_req.req && !msr_req.we && msr_req.addr[7:6] != 2'b00;
    end
  end
  property p_ack; msr_req.req |=> msr_ack; endproperty
  property p_ack_src; msr_ack |-> $past(msr_req.req); endproperty
  property p_gc_rsvd;
    msr_ack && rd_gc_q |-> (msr_rdata & ~GCTRL_RW_MASK) == 64'h0;
  endproperty
  property p_es_rsvd;
    msr_ack && rd_es_q |-> (msr_rdata & ~EVSEL_RW_MASK) == 64'h0;
  endproperty
  property p_unmapped;
    msr_ack && rd_un_q |-> msr_rdata == 64'h0;
  endproperty
  property p_route; ((perf_interrupt | wake_req) & ~route_q) == 4'h0; endproperty
  property p_wake_off; !wake_q |-> wake_req == 4'h0; endproperty
  property p_wake_then; wake_req != 4'h0 |=> perf_interrupt == $past(wake_req); endproperty
  property p_wake_first;
    wake_q && perf_interrupt != 4'h0 |-> $past(wake_req) == perf_interrupt;
  endproperty
  a_ack: assert property (p_ack) else $error("request without ack");
  a_ack_src: assert property (p_ack_src) else $error("ack without request");
  a_gc_rsvd: assert property (p_gc_rsvd) else $error("control reserved bit set");
  a_es_rsvd: assert property (p_es_rsvd) else $error("select reserved bit set");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_route: assert property (p_route) else $error("unrouted core signalled");
  a_wake_off: assert property (p_wake_off) else $error("wake while wake off");
  a_wake_then: assert property (p_wake_then) else $error("wake not followed");
  a_wake_first: assert property (p_wake_first) else $error("interrupt before wake");
  c_irq: cover property (perf_interrupt != 4'h0);
  c_wake: cover property (wake_req != 4'h0);
  c_read: cover property (msr_ack && msr_rdata != 64'h0);
endmodule : uncore_event_counter_unit_checker

bind uncore_event_counter_unit uncore_event_counter_unit_checker u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .msr_req(msr_req), .msr_rdata(msr_rdata),
  .msr_ack(msr_ack), .wake_req(wake_req), .perf_interrupt(perf_interrupt));

// file: bench/core_sink.sv
`timescale 1ns/100ps
module core_sink #(
  parameter logic [3:0] HALTED = 4'h4
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // from the unit
  input  wire logic [3:0] wake_req,
  input  wire logic [3:0] perf_interrupt,
  // interrupts serviced per core
  output logic [3:0][7:0] srv_q
);
  localparam logic [15:0] DBG_CTL = 16'h2000;
  logic [3:0] awake_q;
  // wake then service
  // a halted core sleeps again after servicing, so each wake buys one interrupt
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      awake_q <= ~HALTED;
      srv_q   <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wake_req[i]) awake_q[i] <= 1'b1;
        if (perf_interrupt[i] && awake_q[i] && DBG_CTL[13]) begin
          srv_q[i] <= srv_q[i] + 8'h01;
          if (HALTED[i]) awake_q[i] <= 1'b0;
        end
      end
    end
  end
endmodule : core_sink

// file: bench/test_uncore_event_counter_unit.sv
`timescale 1ns/100ps
module test_uncore_event_counter_unit;
  import uncore_evc_pkg::*;
  localparam int NS = 4;
  localparam int NE = 16;
  localparam int K  = 6;
  // addr, code, {enable, edge, negate, threshold}
  localparam logic [23:0] RUNS [10] = '{24'h10_0180, 24'h11_0183, 24'h10_01a3,
    24'h11_01c0, 24'h10_01e5, 24'h10_0100, 24'h20_8080, 24'h21_8080, 24'h23_0180, 24'h26_0182};
  logic              core_clk;
  logic              rst_n;
  msr_req_t          msr_req;
  logic [63:0]       msr_rdata;
  logic              msr_ack;
  logic [COND_W-1:0] grant_cond [NE];
  logic [COND_W-1:0] slice_cond [NS][NE];
  logic [RAW_W-1:0]  slice_occupancy [NS];
  logic [3:0]        wake_req;
  logic [3:0]        perf_interrupt;
  logic [3:0][7:0]   srv_q;
  logic [31:0]       seed;
  logic [63:0]       rv;
  logic [63:0]       g;
  int                errors;
  int                num_checks;
  int                exp_srv[$];
  uncore_event_counter_unit #(.NUM_SLICES(NS), .N_EV(NE)) DUT (.core_clk(core_clk),
    .rst_n(rst_n), .msr_req(msr_req), .msr_rdata(msr_rdata), .msr_ack(msr_ack),
    .grant_cond(grant_cond), .slice_cond(slice_cond), .slice_occupancy(slice_occupancy),
    .wake_req(wake_req), .perf_interrupt(perf_interrupt));
  core_sink #(.HALTED(4'h4)) u_cores (.core_clk(core_clk), .rst_n(rst_n),
    .wake_req(wake_req), .perf_interrupt(perf_interrupt), .srv_q(srv_q));
  // 20 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // counts expected from one window of K cycles of value v; idle counts nothing
  function automatic int expc(input evsel_t e, input logic [7:0] v, input int slot);
    int p;
    int t;
    if (!e.enable) return 0;
    if (e.event_code >= OCC_EVENT_BASE) p = (slot == 1) ? int'(v[4:0]) : -1;
    else p = (e.event_code == 8'h01) ? $countones(v & e.condition_qualifier) : 0;
    if (p < 0) return 0;
    if (e.threshold_value == 0 && !e.negate_count && !e.edge_detect) return K * p;
    t = (e.threshold_value == 0) ? 1 : int'(e.threshold_value);
    if (((p >= t) ^ e.negate_count) == 0) return 0;
    return e.edge_detect ? 1 : K;
  endfunction : expc
  task stop_test();
    $display("errors %0d num_checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one register access; a missing ack ends the run
  task acc(input logic we, input logic [7:0] a, input logic [63:0] d);
    int i;
    @(posedge core_clk);
    #1 msr_req = '{1'b1, we, a, d};
    @(posedge core_clk);
    #1 msr_req.req = 1'b0;
    for (i = 0; i < 4 && msr_ack !== 1'b1; i++) @(posedge core_clk) #1;
    if (i == 4) begin
      errors++;
      stop_test();
    end
    rv = msr_rdata;
  endtask : acc
  task rd(input logic [7:0] a, input logic [63:0] e);
    acc(1'b0, a, 64'h0);
    chk(rv, e);
  endtask : rd
  // all counters see the same value on event 1 and on occupancy
  task drv(input logic [7:0] v);
    grant_cond[1] = v;
    for (int s = 0; s < NS; s++) begin
      slice_cond[s][1]   = v;
      slice_occupancy[s] = v[4:0];
    end
  endtask : drv
  initial begin
    rst_n   = 1'b0;
    seed    = 32'h0000_7c0c;
    msr_req = '0;
    errors  = 0;
    num_checks = 0;
    exp_srv = '{1, 2, 2};
    for (int n = 0; n < NE; n++) begin
      grant_cond[n] = 8'h00;
      for (int s = 0; s < NS; s++) slice_cond[s][n] = 8'h00;
    end
    drv(8'h00);
    repeat (5) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge core_clk);
    rd(IDX_GLOBAL_CTRL, GCTRL_RESET);
    rd(8'h40, 64'h0);
    acc(1'b1, IDX_GLOBAL_CTRL, 64'hffff_ffff_dfff_ffff);
    rd(IDX_GLOBAL_CTRL, 64'h0000_0000_c000_000f);
    acc(1'b1, IDX_GLOBAL_CTRL, 64'h0000_0000_2000_0000);
    acc(1'b0, IDX_FIXED_CTR, 64'h0);
    rd(IDX_FIXED_CTR, rv + 64'h2);
    // filter modes and counter placement
    for (int r = 0; r < 10; r++) begin
      evsel_t      e;
      logic [31:0] x;
      logic [7:0]  a;
      logic [7:0]  ca;
      int          xp;
      x = rnd();
      a = RUNS[r][23:16];
      e = '0;
      e.event_code = RUNS[r][15:8];
      e.enable = RUNS[r][7];
      e.edge_detect = RUNS[r][6];
      e.negate_count = RUNS[r][5];
      e.threshold_value = RUNS[r][4:0];
      e.condition_qualifier = x[15:8] | {8{e.negate_count}};
      ca = a[5] ? a + 8'h10 : a + 8'h02;
      drv(e.negate_count ? 8'hff : 8'h00);
      acc(1'b1, ca, 64'h0);
      acc(1'b1, a, e | {x, 32'h0});
      rd(a, e);
      drv(x[7:0]);
      repeat (K) @(posedge core_clk);
      #1 drv(e.negate_count ? 8'hff : 8'h00);
      xp = expc(e, x[7:0], a < 8'h20 ? 0 : (a[0] ? 2 : 1));
      rd(ca, 64'(xp));
      acc(1'b1, a, 64'h0);
    end
    // overflow: wake and forward, no wake, no forward
    for (int w = 0; w < 3; w++) begin
      evsel_t e;
      e = '0;
      e.event_code = 8'h01;
      e.condition_qualifier = 8'h01;
      e.enable = 1'b1;
      e.overflow_forward_enable = (w != 2);
      g = {32'h0, 1'b1, w != 1, 1'b1, 25'h0, 4'h5};
      acc(1'b1, IDX_GRANT_CTR, 64'h0000_0fff_ffff_fffe);
      acc(1'b1, IDX_GRANT_SEL, e);
      acc(1'b1, IDX_GLOBAL_CTRL, g);
      drv(8'h01);
      repeat (2) @(posedge core_clk);
      #1 drv(8'h00);
      repeat (6) @(posedge core_clk);
      // frozen counters must ignore events that arrive after the freeze
      #1 drv(8'h01);
      chk(64'(srv_q[0]), 64'(exp_srv[w]));
      chk(64'(srv_q[2]), 64'h1);
      repeat (3) @(posedge core_clk);
      #1 drv(8'h00);
      rd(IDX_GLOBAL_CTRL, g & ~64'h0000_0000_2000_0000);
      rd(IDX_GRANT_CTR, 64'h0);
      acc(1'b1, IDX_GRANT_SEL, 64'h0);
    end
    acc(1'b0, IDX_FIXED_CTR, 64'h0);
    rd(IDX_FIXED_CTR, rv);
    acc(1'b1, 8'h05, 64'hffff_ffff_ffff_ffff);
    rd(8'h05, 64'h0);
    stop_test();
  end
endmodule : test_uncore_event_counter_unit
